// [verilog/sesr_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - conflicting command answers E, two digits, CR
// - refuse setpoint when 105% exceeds overvoltage: E01
// - refuse setpoint below 105% undervoltage: E02
// - refuse overvoltage below 105% setpoint: E04
// - refuse undervoltage when 105% exceeds setpoint: E06
// - output on during fault shutdown: E07
// - second mode or empty cell: E08
// - at most one operation mode active
// - only service request goes out unprompted
// - request when event register leaves zero
// - later events accumulate, no further requests
// - request: byte, space, byte, CR
// - gateway for up to 31 chained units
// - selected unit gets all later commands except select, select query and unknown ones
// - own unit selected after reset
// - bus interface forces 115200 and SCPI
// - bus address follows unit address
// - unknown command or parameter answers C
// - reading event register clears it
module sesr_top
   import sesr_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                sys_rst,
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   input  wire logic                cmd_valid,
   output logic                     cmd_ready,
   input  wire sesr_pkg::sesr_cmd_t cmd_code,
   input  wire logic [15:0]         cmd_value,
   input  wire logic [3:0]          cmd_arg,
   input  wire logic [15:0]         status_evt_in,
   input  wire logic [15:0]         fault_evt_in,
   input  wire logic                fault_shutdown,
   input  wire logic [15:0]         mem_cell_full,
   output logic                     tx_valid,
   input  wire logic                tx_ready,
   output logic      [7:0]          tx_data,
   output logic                     fwd_valid,
   output logic      [4:0]          fwd_addr,
   output sesr_pkg::sesr_cmd_t      fwd_code,
   output logic      [15:0]         fwd_value,
   output logic      [3:0]          fwd_arg,
   output logic      [15:0]         voltage_setpoint,
   output logic      [15:0]         overvoltage_limit,
   output logic      [15:0]         undervoltage_limit,
   output logic                     output_on,
   output logic      [4:0]          mode_active,
   output logic                     recall_pulse,
   output logic      [3:0]          recall_cell,
   output logic      [4:0]          bus_address,
   output logic      [16:0]         link_rate,
   output logic                     link_lang_scpi
);
   import sesr_pkg::*;

   function automatic logic [22:0] pct(input logic [15:0] v,
                                       input logic [22:0] p);
      pct = 23'(v) * p;
   endfunction

   function automatic logic [7:0] digit(input logic [3:0] d);
      digit = CH_ZERO + {4'h0, d};
   endfunction

   sesr_state_t state_q;
   logic [7:0]  msg_q [4];
   logic [1:0]  idx_q;
   logic [1:0]  last_q;
   logic [4:0]  unit_addr_q;
   logic        if_sel_q;
   logic [16:0] rate_q;
   logic        lang_q;
   logic        sel_local_q;
   logic [4:0]  sel_addr_q;
   logic [15:0] pv_q, ovp_q, uvl_q;
   logic        out_q;
   logic [4:0]  mode_q;
   logic [15:0] status_event_register_q, fault_event_register_q;
   logic [15:0] status_event_register_base, fault_event_register_base, status_event_register_d, fault_event_register_d;
   logic        srq_pend_q, srq_trig, srq_load;
   logic        cmd_take, is_sel, run_local, forward;
   logic [3:0]  e_code, c_code;
   logic        apply, reply_err, reply_sel;
   logic [4:0]  mode_one;
   logic [3:0]  tens, ones;
   logic [7:0]  srq_byte;
   logic        tx_start;

   assign cmd_ready = (state_q == ST_IDLE);
   assign cmd_take  = cmd_valid && cmd_ready;
   assign is_sel    = (cmd_code == CMD_SELECT) ||
                      (cmd_code == CMD_SELECT_Q) || (cmd_code == CMD_BAD);
   assign run_local = cmd_take && (sel_local_q || is_sel);
   assign forward   = cmd_take && !sel_local_q && !is_sel;
   assign mode_one  = 5'h01 << cmd_arg[2:0];
   assign srq_byte  = SRQ_BASE | {3'h0, unit_addr_q};

   // conflict checks ahead of any setting change
   always_comb begin
      e_code = 4'h0;
      c_code = 4'h0;
      case (cmd_code)
         CMD_SET_PV: begin
            if (pct(cmd_value, PCT_MARGIN) > pct(ovp_q, PCT_FULL)) begin
               e_code = E_OVER_OVP;
            end else if (pct(cmd_value, PCT_FULL) <
                         pct(uvl_q, PCT_MARGIN)) begin
               e_code = E_UNDER_UVL;
            end
         end
         CMD_SET_OVP: begin
            if (pct(cmd_value, PCT_FULL) < pct(pv_q, PCT_MARGIN)) begin
               e_code = E_OVP_LOW;
            end
         end
         CMD_SET_UVL: begin
            if (pct(cmd_value, PCT_MARGIN) > pct(pv_q, PCT_FULL)) begin
               e_code = E_UVL_HIGH;
            end
         end
         CMD_OUT_ON: begin
            if (fault_shutdown) begin
               e_code = E_FAULT_ON;
            end
         end
         CMD_MODE_ON: begin
            if (cmd_arg > {1'b0, MODE_LAST}) begin
               c_code = C_BAD_PARAM;
            end else if (mode_q != 5'h00 && mode_q != mode_one) begin
               e_code = E_GENERAL;
            end
         end
         CMD_MODE_OFF: begin
            if (cmd_arg > {1'b0, MODE_LAST}) begin
               c_code = C_BAD_PARAM;
            end
         end
         CMD_RECALL: begin
            if (!mem_cell_full[cmd_arg]) begin
               e_code = E_GENERAL;
            end
         end
         CMD_SELECT: begin
            if (cmd_value > ADDR_MAX) begin
               c_code = C_BAD_PARAM;
            end
         end
         CMD_BAD: c_code = C_ILLEGAL;
         default: begin
            e_code = 4'h0;
            c_code = 4'h0;
         end
      endcase
   end

   assign reply_err = run_local && (e_code != 4'h0 || c_code != 4'h0);
   assign reply_sel = run_local && (cmd_code == CMD_SELECT_Q);
   assign apply     = run_local && !reply_err;
   assign srq_load  = cmd_ready && !cmd_valid && srq_pend_q;
   assign tx_start  = reply_err || reply_sel || srq_load;

   always_comb begin
      tens = 4'h0;
      ones = 4'h0;
      if (sel_addr_q >= 5'h1E) begin
         tens = 4'h3;
         ones = 4'(sel_addr_q - 5'h1E);
      end else if (sel_addr_q >= 5'h14) begin
         tens = 4'h2;
         ones = 4'(sel_addr_q - 5'h14);
      end else if (sel_addr_q >= 5'h0A) begin
         tens = 4'h1;
         ones = 4'(sel_addr_q - 5'h0A);
      end else begin
         ones = sel_addr_q[3:0];
      end
   end

   // outgoing messages: replies and the service request only
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         idx_q   <= 2'h0;
         last_q  <= 2'h0;
         for (int i = 0; i < 4; i++) begin
            msg_q[i] <= 8'h00;
         end
      end else begin
         case (state_q)
            ST_IDLE: begin
               idx_q <= 2'h0;
               if (reply_err) begin
                  state_q  <= ST_SEND;
                  msg_q[0] <= (e_code != 4'h0) ? CH_EXEC : CH_CMD;
                  msg_q[1] <= CH_ZERO;
                  msg_q[2] <= digit((e_code != 4'h0) ? e_code : c_code);
                  msg_q[3] <= CH_CR;
                  last_q   <= 2'h3;
               end else if (reply_sel) begin
                  state_q  <= ST_SEND;
                  msg_q[0] <= digit(tens);
                  msg_q[1] <= digit(ones);
                  msg_q[2] <= CH_CR;
                  last_q   <= 2'h2;
               end else if (srq_load) begin
                  state_q  <= ST_SEND;
                  msg_q[0] <= srq_byte;
                  msg_q[1] <= CH_SPACE;
                  msg_q[2] <= srq_byte;
                  msg_q[3] <= CH_CR;
                  last_q   <= 2'h3;
               end
            end
            ST_SEND: begin
               if (tx_ready) begin
                  idx_q <= idx_q + 2'h1;
                  if (idx_q == last_q) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign tx_valid = (state_q == ST_SEND);
   assign tx_data  = msg_q[idx_q];

   // settings and modes
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pv_q         <= PV_RST;
         ovp_q        <= OVP_RST;
         uvl_q        <= UVL_RST;
         out_q        <= 1'b0;
         mode_q       <= 5'h00;
         recall_pulse <= 1'b0;
         recall_cell  <= 4'h0;
      end else begin
         recall_pulse <= 1'b0;
         if (apply) begin
            case (cmd_code)
               CMD_SET_PV:   pv_q  <= cmd_value;
               CMD_SET_OVP:  ovp_q <= cmd_value;
               CMD_SET_UVL:  uvl_q <= cmd_value;
               CMD_OUT_ON:   out_q <= 1'b1;
               CMD_OUT_OFF:  out_q <= 1'b0;
               CMD_MODE_ON:  mode_q <= mode_one;
               CMD_MODE_OFF: mode_q <= mode_q & ~mode_one;
               CMD_RECALL: begin
                  recall_pulse <= 1'b1;
                  recall_cell  <= cmd_arg;
               end
               default: out_q <= out_q;
            endcase
         end
      end
   end

   // unit selection and forwarding into the chain
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_local_q <= 1'b1;
         sel_addr_q  <= UNIT_ADDR_RST;
         fwd_valid   <= 1'b0;
         fwd_addr    <= 5'h00;
         fwd_code    <= CMD_OTHER;
         fwd_value   <= 16'h0000;
         fwd_arg     <= 4'h0;
      end else begin
         fwd_valid <= forward;
         if (forward) begin
            fwd_addr  <= sel_addr_q;
            fwd_code  <= cmd_code;
            fwd_value <= cmd_value;
            fwd_arg   <= cmd_arg;
         end
         if (apply && cmd_code == CMD_SELECT) begin
            sel_addr_q  <= cmd_value[4:0];
            sel_local_q <= (cmd_value[4:0] == unit_addr_q);
         end else if (sel_local_q) begin
            sel_addr_q <= unit_addr_q;
         end
      end
   end

   // event registers, cleared by reading, set wins over clear
   always_comb begin
      status_event_register_base = (reg_rd && reg_addr == REG_STATUS_EVT) ? 16'h0000 : status_event_register_q;
      fault_event_register_base = (reg_rd && reg_addr == REG_FAULT_EVT) ? 16'h0000 : fault_event_register_q;
      status_event_register_d    = status_event_register_base | status_evt_in;
      fault_event_register_d    = fault_event_register_base | fault_evt_in;
      srq_trig  = (status_event_register_base == 16'h0000 && status_event_register_d != 16'h0000) ||
                  (fault_event_register_base == 16'h0000 && fault_event_register_d != 16'h0000);
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_event_register_q     <= 16'h0000;
         fault_event_register_q     <= 16'h0000;
         srq_pend_q <= 1'b0;
      end else begin
         status_event_register_q     <= status_event_register_d;
         fault_event_register_q     <= fault_event_register_d;
         srq_pend_q <= srq_trig || (srq_pend_q && !srq_load);
      end
   end

   // register port
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         unit_addr_q <= UNIT_ADDR_RST;
         if_sel_q    <= IF_SEL_RST;
         rate_q      <= LINK_RATE_RST;
         lang_q      <= LINK_LANG_RST;
      end else if (reg_wr) begin
         if (reg_addr == REG_UNIT_ADDR) begin
            unit_addr_q <= reg_wdata[4:0];
         end else if (reg_addr == REG_IF_SEL) begin
            if_sel_q <= reg_wdata[0];
         end else if (reg_addr == REG_LINK) begin
            rate_q <= reg_wdata[16:0];
            lang_q <= reg_wdata[LINK_LANG_BIT];
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (!reg_rd) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == REG_UNIT_ADDR) begin
         reg_rdata <= {27'h0, unit_addr_q};
      end else if (reg_addr == REG_IF_SEL) begin
         reg_rdata <= {31'h0, if_sel_q};
      end else if (reg_addr == REG_STATUS_EVT) begin
         reg_rdata <= {16'h0, status_event_register_q};
      end else if (reg_addr == REG_FAULT_EVT) begin
         reg_rdata <= {16'h0, fault_event_register_q};
      end else if (reg_addr == REG_STATE) begin
         reg_rdata <= {15'h0, out_q, 3'h0, mode_q, 2'h0,
                       sel_local_q, sel_addr_q};
      end else if (reg_addr == REG_LINK) begin
         reg_rdata <= {14'h0, link_lang_scpi, link_rate};
      end else if (reg_addr == REG_SETPOINT) begin
         reg_rdata <= {ovp_q, pv_q};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   assign voltage_setpoint   = pv_q;
   assign overvoltage_limit  = ovp_q;
   assign undervoltage_limit = uvl_q;
   assign output_on          = out_q;
   assign mode_active        = mode_q;
   assign bus_address        = unit_addr_q;
   assign link_rate          = if_sel_q ? LINK_RATE_BUS : rate_q;
   assign link_lang_scpi     = if_sel_q ? LANG_SCPI : lang_q;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_err_sent(logic [7:0] d);
      tx_valid && msg_q[0] == CH_EXEC && msg_q[1] == CH_ZERO &&
      msg_q[2] == d && msg_q[3] == CH_CR;
   endsequence
   property p_e01;
      reply_err && cmd_code == CMD_SET_PV && e_code == E_OVER_OVP
      |=> s_err_sent(8'h31) && $stable(pv_q);
   endproperty
   a_e01: assert property (p_e01) else $error("E01 not sent");
   property p_e02;
      run_local && cmd_code == CMD_SET_PV &&
      pct(cmd_value, PCT_MARGIN) <= pct(ovp_q, PCT_FULL) &&
      pct(cmd_value, PCT_FULL) < pct(uvl_q, PCT_MARGIN)
      |=> s_err_sent(8'h32);
   endproperty
   a_e02: assert property (p_e02) else $error("E02 not sent");
   property p_e04;
      run_local && cmd_code == CMD_SET_OVP &&
      pct(cmd_value, PCT_FULL) < pct(pv_q, PCT_MARGIN)
      |=> s_err_sent(8'h34) && $stable(ovp_q);
   endproperty
   a_e04: assert property (p_e04) else $error("E04 not sent");
   property p_e06;
      run_local && cmd_code == CMD_SET_UVL &&
      pct(cmd_value, PCT_MARGIN) > pct(pv_q, PCT_FULL)
      |=> s_err_sent(8'h36) && $stable(uvl_q);
   endproperty
   a_e06: assert property (p_e06) else $error("E06 not sent");
   property p_e07;
      run_local && cmd_code == CMD_OUT_ON && fault_shutdown && !out_q
      |=> s_err_sent(8'h37) && !out_q;
   endproperty
   a_e07: assert property (p_e07) else $error("E07 not sent");
   property p_one_mode;
      $onehot0(mode_q);
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("two modes");
   property p_unprompted;
      $rose(tx_valid) |-> $past(tx_start);
   endproperty
   a_unprompted: assert property (p_unprompted) else $error("stray tx");
   property p_srq_once;
      srq_trig |-> ##[1:300] (tx_valid && msg_q[0] == srq_byte &&
                  msg_q[1] == CH_SPACE && msg_q[3] == CH_CR);
   endproperty
   a_srq_once: assert property (p_srq_once) else $error("no request");
   property p_no_more;
      status_event_register_q != 16'h0000 && !(reg_rd && reg_addr == REG_STATUS_EVT) &&
      (fault_event_register_q != 16'h0000 || fault_evt_in == 16'h0000) &&
      !(reg_rd && reg_addr == REG_FAULT_EVT) && !srq_pend_q
      |=> !srq_pend_q;
   endproperty
   a_no_more: assert property (p_no_more) else $error("extra request");
   property p_fwd;
      forward |=> fwd_valid && fwd_addr == $past(sel_addr_q) && !tx_valid;
   endproperty
   a_fwd: assert property (p_fwd) else $error("not forwarded");
   property p_clear;
      reg_rd && reg_addr == REG_STATUS_EVT && status_evt_in == 16'h0000
      |=> status_event_register_q == 16'h0000 && reg_rdata[15:0] == $past(status_event_register_q);
   endproperty
   a_clear: assert property (p_clear) else $error("no read clear");
endmodule
`default_nettype wire

// [verilog/sesr_pkg.sv]
`default_nettype none
package sesr_pkg;
   // register byte offsets
   localparam logic [7:0] REG_UNIT_ADDR  = 8'h00;
   localparam logic [7:0] REG_IF_SEL     = 8'h04;
   localparam logic [7:0] REG_STATUS_EVT = 8'h08;
   localparam logic [7:0] REG_FAULT_EVT  = 8'h0C;
   localparam logic [7:0] REG_STATE      = 8'h10;
   localparam logic [7:0] REG_LINK       = 8'h14;
   localparam logic [7:0] REG_SETPOINT   = 8'h18;
   // field positions
   localparam int STATE_SEL_LSB   = 0;
   localparam int STATE_LOCAL_BIT = 5;
   localparam int STATE_MODE_LSB  = 8;
   localparam int STATE_OUT_BIT   = 16;
   localparam int LINK_LANG_BIT   = 17;
   // reset values
   localparam logic [4:0]  UNIT_ADDR_RST = 5'h00;
   localparam logic        IF_SEL_RST    = 1'b1;
   localparam logic [16:0] LINK_RATE_RST = 17'h1C200;
   localparam logic        LINK_LANG_RST = 1'b0;
   localparam logic [15:0] PV_RST        = 16'h0000;
   localparam logic [15:0] OVP_RST       = 16'hFFFF;
   localparam logic [15:0] UVL_RST       = 16'h0000;
   // forced link settings on the instrument bus
   localparam logic [16:0] LINK_RATE_BUS = 17'h1C200;
   localparam logic        LANG_SCPI     = 1'b1;
   // margins in percent, highest unit address and last mode
   localparam logic [22:0] PCT_MARGIN = 23'h000069;
   localparam logic [22:0] PCT_FULL   = 23'h000064;
   localparam logic [15:0] ADDR_MAX   = 16'h001F;
   localparam logic [2:0]  MODE_LAST  = 3'h4;
   // reply characters
   localparam logic [7:0] CH_EXEC  = 8'h45;
   localparam logic [7:0] CH_CMD   = 8'h43;
   localparam logic [7:0] CH_ZERO  = 8'h30;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] SRQ_BASE = 8'h80;
   // execution and command error digits
   localparam logic [3:0] E_OVER_OVP  = 4'h1;
   localparam logic [3:0] E_UNDER_UVL = 4'h2;
   localparam logic [3:0] E_OVP_LOW   = 4'h4;
   localparam logic [3:0] E_UVL_HIGH  = 4'h6;
   localparam logic [3:0] E_FAULT_ON  = 4'h7;
   localparam logic [3:0] E_GENERAL   = 4'h8;
   localparam logic [3:0] C_ILLEGAL   = 4'h1;
   localparam logic [3:0] C_BAD_PARAM = 4'h3;

   typedef enum logic [3:0] {
      CMD_SET_PV   = 4'h0,
      CMD_SET_OVP  = 4'h1,
      CMD_SET_UVL  = 4'h2,
      CMD_OUT_ON   = 4'h3,
      CMD_OUT_OFF  = 4'h4,
      CMD_MODE_ON  = 4'h5,
      CMD_MODE_OFF = 4'h6,
      CMD_RECALL   = 4'h7,
      CMD_SELECT   = 4'h8,
      CMD_SELECT_Q = 4'h9,
      CMD_BAD      = 4'hA,
      CMD_OTHER    = 4'hB
   } sesr_cmd_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } sesr_state_t;
endpackage
`default_nettype wire

// [bench/sesr_host_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module sesr_host_sink (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       slow,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready
);
   logic [7:0] rx_q[$];
   logic [2:0] cnt_q;
   // host takes bytes at once, or stalls every other pair in slow mode
   always @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 3'h0;
         tx_ready <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 3'h1;
         tx_ready <= !slow || cnt_q[1];
         if (tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
         end
      end
   end
endmodule
`default_nettype wire

// [bench/sesr_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sesr_tb_top;
   import sesr_pkg::*;
   logic        core_clk, sys_rst, reg_wr, reg_rd, cmd_valid, slow;
   logic        cmd_ready, tx_valid, tx_ready, fwd_valid, output_on;
   logic        recall_pulse, link_lang_scpi, fault_shutdown;
   logic [7:0]  reg_addr, tx_data;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic [15:0] cmd_value, status_evt_in, fault_evt_in, mem_cell_full;
   logic [15:0] fwd_value, voltage_setpoint, overvoltage_limit;
   logic [15:0] undervoltage_limit, pv_m, v;
   logic [3:0]  cmd_arg, fwd_arg, recall_cell, d;
   logic [4:0]  fwd_addr, mode_active, bus_address;
   logic [16:0] link_rate;
   sesr_cmd_t   cmd_code, fwd_code;
   int          miscompares, compares, seed;

   sesr_top sesr_top_inst (.core_clk, .sys_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .cmd_ready, .cmd_code,
      .cmd_value, .cmd_arg, .status_evt_in, .fault_evt_in, .fault_shutdown,
      .mem_cell_full, .tx_valid, .tx_ready, .tx_data, .fwd_valid, .fwd_addr,
      .fwd_code, .fwd_value, .fwd_arg, .voltage_setpoint, .overvoltage_limit,
      .undervoltage_limit, .output_on, .mode_active, .recall_pulse,
      .recall_cell, .bus_address, .link_rate, .link_lang_scpi);
   sesr_host_sink sesr_host_sink_inst (.core_clk, .sys_rst, .slow,
      .tx_valid, .tx_data, .tx_ready);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = !core_clk;
   end

   function automatic logic [31:0] emsg(input logic [7:0] c,
                                        input logic [3:0] n);
      return {c, CH_ZERO, CH_ZERO | {4'h0, n}, CH_CR};
   endfunction
   function automatic logic [3:0] pv_err(input logic [15:0] x);
      if (105 * x > 100 * 1050) return E_OVER_OVP;
      if (100 * x < 105 * 952) return E_UNDER_UVL;
      return 4'h0;
   endfunction

   task print_verdict;
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cmd(input sesr_cmd_t c, input logic [15:0] x, input logic [3:0] a);
      @(posedge core_clk);
      cmd_code <= c;
      cmd_value <= x;
      cmd_arg <= a;
      cmd_valid <= 1'b1;
      do @(negedge core_clk); while (cmd_ready !== 1'b1);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      @(negedge core_clk);
   endtask
   task chk_msg(input string nm, input logic [31:0] e, input int n);
      logic [31:0] g;
      g = 32'h0;
      for (int i = 0; i < 80 && sesr_host_sink_inst.rx_q.size() < n; i++)
         @(negedge core_clk);
      repeat (n) g = {g[23:0], sesr_host_sink_inst.rx_q.pop_front()};
      chk(nm, e, g);
   endtask
   task quiet(input string nm);
      repeat (10) @(negedge core_clk);
      chk(nm, 0, sesr_host_sink_inst.rx_q.size());
   endtask
   task reg_write(input logic [7:0] a, input logic [31:0] x);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(negedge core_clk);
   endtask
   task reg_read(input logic [7:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      rd = reg_rdata;
   endtask
   task evt(input logic [15:0] s, input logic [15:0] f);
      @(posedge core_clk);
      status_evt_in <= s;
      fault_evt_in <= f;
      @(posedge core_clk);
      status_evt_in <= 16'h0;
      fault_evt_in <= 16'h0;
   endtask

   initial begin
      #2000000;
      miscompares++;
      print_verdict();
   end

   initial begin
      seed = 66459;
      sys_rst = 1'b1;
      {reg_wr, reg_rd, cmd_valid, fault_shutdown, slow} = 5'h00;
      {reg_addr, reg_wdata, cmd_value, cmd_arg} = '0;
      {status_evt_in, fault_evt_in} = 32'h0;
      mem_cell_full = 16'h0002;
      cmd_code = CMD_OTHER;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(negedge core_clk);
      chk("ovp_rst", 32'hFFFF, overvoltage_limit);
      chk("rate", LINK_RATE_BUS, link_rate);
      chk("lang", 1, link_lang_scpi);
      reg_read(REG_STATE);
      chk("sel_self", 32'h20, rd & 32'h3F);
      reg_write(REG_UNIT_ADDR, 32'h5);
      chk("bus_addr", 5, bus_address);
      reg_write(REG_IF_SEL, 32'h0);
      reg_write(REG_LINK, 32'h2580);
      chk("rate_free", 32'h2580, link_rate);
      reg_write(REG_IF_SEL, 32'h1);
      chk("rate_bus", LINK_RATE_BUS, link_rate);
      chk("lang_bus", 1, link_lang_scpi);
      reg_read(8'h40);
      chk("unmapped", 0, rd);
      $display("test regs done");
      cmd(CMD_SET_PV, 16'd1000, 4'h0);
      cmd(CMD_SET_OVP, 16'd1049, 4'h0);
      chk_msg("e04", emsg(CH_EXEC, E_OVP_LOW), 4);
      chk("ovp_kept", 32'hFFFF, overvoltage_limit);
      cmd(CMD_SET_OVP, 16'd1050, 4'h0);
      cmd(CMD_SET_UVL, 16'd953, 4'h0);
      chk_msg("e06", emsg(CH_EXEC, E_UVL_HIGH), 4);
      cmd(CMD_SET_UVL, 16'd952, 4'h0);
      chk("uvl", 952, undervoltage_limit);
      quiet("no_reply");
      pv_m = 16'd1000;
      slow <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         v = 16'(((i == 0) ? 1001 : (i == 1) ? 999 : 900)
              + ((i < 2) ? 0 : ($random(seed) & 255)));
         d = pv_err(v);
         cmd(CMD_SET_PV, v, 4'h0);
         if (d != 4'h0) chk_msg("pv_err", emsg(CH_EXEC, d), 4);
         else pv_m = v;
         chk("pv", pv_m, voltage_setpoint);
      end
      slow <= 1'b0;
      $display("test limits done");
      fault_shutdown <= 1'b1;
      cmd(CMD_OUT_ON, 16'h0, 4'h0);
      chk_msg("e07", emsg(CH_EXEC, E_FAULT_ON), 4);
      chk("out_off", 0, output_on);
      fault_shutdown <= 1'b0;
      cmd(CMD_OUT_ON, 16'h0, 4'h0);
      chk("out_on", 1, output_on);
      for (int m = 0; m < 5; m++) begin
         cmd(CMD_MODE_ON, 16'h0, 4'(m));
         cmd(CMD_MODE_ON, 16'h0, 4'((m + 1) % 5));
         chk_msg("e08", emsg(CH_EXEC, E_GENERAL), 4);
         chk("mode", 32'h1 << m, mode_active);
         cmd(CMD_MODE_OFF, 16'h0, 4'(m));
      end
      cmd(CMD_MODE_ON, 16'h0, 4'h5);
      chk_msg("c03_mode", emsg(CH_CMD, C_BAD_PARAM), 4);
      chk("mode_kept", 0, mode_active);
      cmd(CMD_OUT_OFF, 16'h0, 4'h0);
      chk("out_off2", 0, output_on);
      cmd(CMD_RECALL, 16'h0, 4'h0);
      chk_msg("empty", emsg(CH_EXEC, E_GENERAL), 4);
      cmd(CMD_RECALL, 16'h0, 4'h1);
      chk("cell", 1, recall_cell);
      chk("recall", 1, recall_pulse);
      cmd(CMD_BAD, 16'h0, 4'h0);
      chk_msg("c01", emsg(CH_CMD, C_ILLEGAL), 4);
      $display("test errors done");
      evt(16'h0004, 16'h0);
      chk_msg("srq", 32'h8520850D, 4);
      evt(16'h0010, 16'h0);
      quiet("srq_once");
      reg_read(REG_STATUS_EVT);
      chk("sevt", 32'h14, rd);
      reg_read(REG_STATUS_EVT);
      chk("sevt_clr", 0, rd);
      evt(16'h0, 16'h0002);
      chk_msg("srq_f", 32'h8520850D, 4);
      $display("test srq done");
      cmd(CMD_SELECT, 16'd3, 4'h0);
      cmd(CMD_SELECT_Q, 16'h0, 4'h0);
      chk_msg("sel_q", 32'h0030330D, 3);
      cmd(CMD_SET_PV, 16'd500, 4'h0);
      chk("fwd", 1, fwd_valid);
      chk("fwd_addr", 3, fwd_addr);
      chk("fwd_val", 500, fwd_value);
      chk("fwd_code", CMD_SET_PV, fwd_code);
      chk("pv_local", pv_m, voltage_setpoint);
      cmd(CMD_SELECT, 16'd32, 4'h0);
      chk_msg("c03", emsg(CH_CMD, C_BAD_PARAM), 4);
      cmd(CMD_SELECT, 16'd5, 4'h0);
      reg_read(REG_STATE);
      chk("sel_back", 32'h25, rd & 32'h3F);
      $display("test select done");
      print_verdict();
   end
endmodule
`default_nettype wire
